//--- rtl/fgar_pkg.sv
// Constants for the fast address-gate and alternate CPU reset block.
// Assumes a single 40 MHz system clock.
package fgar_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int CLK_KHZ = 40000;
   localparam int PERIOD_NS = 25;
   localparam int DELAY_US = 14;
   localparam int PULSE_US = 6;
   // Least times round up
   localparam int DELAY_CYC = DELAY_US * CLK_MHZ;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int KBC_RST_PERIODS = 24;
   localparam int KBC_RST_REF_MHZ = 16;
   // 24 periods of 16 MHz = 1500 ns, rounded up to whole clock cycles
   localparam int KBC_RST_NS = (KBC_RST_PERIODS * 1000) / KBC_RST_REF_MHZ;
   localparam int KBC_RST_CYC = (KBC_RST_NS + PERIOD_NS - 1) / PERIOD_NS;
   localparam int REF_KHZ = 14318;
   localparam int KBC_KHZ = 12000;
   localparam int CNT_W = 10;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_FAST_PORT = 8'h92;
   localparam logic [7:0] ADDR_GATE_CFG = 8'hF0;
   localparam logic [7:0] FAST_PORT_RESET = 8'h24;
   localparam logic [7:0] FAST_PORT_FIXED = 8'h24;
   localparam logic [7:0] GATE_CFG_RESET = 8'h00;
   localparam int BIT_RST = 0;
   localparam int BIT_GATE = 1;
   localparam int BIT_EN = 2;
endpackage : fgar_pkg

//--- rtl/fgar_top.sv
// Fast address-gate and alternate CPU reset logic beside the keyboard controller.
// Assumes a 40 MHz clock, a synchronous host register port and synchronous
// keyboard-controller signals; the 14.318 MHz reference is a sampled input.
`timescale 1ns/1ps

// Summary of operation
// - Derive 12 MHz controller enable from 14.318 MHz
// - Controller reset held at least 24 16MHz periods
// - Host bus reset pin is sole reset
// - Gate/reset from controller or fast port
// - Fast port accessed only when enable bit set
// - Reserved bits read fixed 00100100 pattern
// - Address gate follows written bit 1
// - Bit 0 set: wait 14us, pulse 6us low
// - No new pulse until bit 0 cleared
// - Reset clears bit 0, reset output high
// - Combined reset ANDs both (fast reset only while port enabled), programmable polarity
// - Address mask is OR of gates
// - Address gate low after reset
// - Controller port bit drives software gate
module fgar_top #(
   parameter int DELAY_CYC = fgar_pkg::DELAY_CYC,
   parameter int PULSE_CYC = fgar_pkg::PULSE_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ref_clk,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_kbc_gate_port_bit,
   input wire logic i_kbc_cpu_reset_n,
   input wire logic i_reset_polarity,
   output logic o_kbc_clk_en,
   output logic o_kbc_reset_n,
   output logic o_fast_address_gate,
   output logic o_fast_cpu_reset_n,
   output logic o_cpu_address_mask_n,
   output logic o_combined_cpu_reset,
   output logic o_kbd_clock_line,
   output logic o_kbd_data_line,
   output logic o_mouse_clock_line,
   output logic o_mouse_data_line,
   output logic [7:0] o_host_status
);

   // ----------------------------------------
   // Types and state
   // ----------------------------------------
   typedef enum logic [1:0] {FGAR_IDLE, FGAR_WAIT, FGAR_PULSE, FGAR_DONE} fgar_state_t;

   fgar_state_t state;
   logic [7:0] gate_cfg;
   logic fast_gate;
   logic fast_rst_bit;
   logic [fgar_pkg::CNT_W-1:0] cnt;
   logic ref_d;
   logic [15:0] acc;
   logic [5:0] kbc_rst_cnt;
   logic port_en;
   logic port_hit;

   assign port_en = gate_cfg[fgar_pkg::BIT_EN];
   assign port_hit = port_en && (i_addr == fgar_pkg::ADDR_FAST_PORT);

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Configuration register holds the fast port enable
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         gate_cfg <= fgar_pkg::GATE_CFG_RESET;
      end else if (i_wr && i_addr == fgar_pkg::ADDR_GATE_CFG) begin
         gate_cfg <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         fast_gate <= 1'b0;
         fast_rst_bit <= 1'b0;
      end else if (i_wr && port_hit) begin
         fast_gate <= i_wdata[fgar_pkg::BIT_GATE];
         fast_rst_bit <= i_wdata[fgar_pkg::BIT_RST];
      end
   end

   // Unmapped or disabled reads return zero
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd && port_hit) begin
         o_rdata <= fgar_pkg::FAST_PORT_FIXED | {6'h00, fast_gate, fast_rst_bit};
      end else if (i_rd && i_addr == fgar_pkg::ADDR_GATE_CFG) begin
         o_rdata <= gate_cfg;
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Alternate reset sequencer
   // ----------------------------------------
   // Rising write of bit 0 arms; DONE blocks a repeat until bit 0 is cleared
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state <= FGAR_IDLE;
         cnt <= '0;
      end else begin
         unique case (state)
            FGAR_IDLE: begin
               if (fast_rst_bit) begin
                  state <= FGAR_WAIT;
                  cnt <= '0;
               end
            end
            FGAR_WAIT: begin
               if (cnt == fgar_pkg::CNT_W'(DELAY_CYC - 1)) begin
                  state <= FGAR_PULSE;
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            FGAR_PULSE: begin
               if (cnt == fgar_pkg::CNT_W'(PULSE_CYC - 1)) begin
                  state <= FGAR_DONE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            FGAR_DONE: begin
               if (!fast_rst_bit) begin
                  state <= FGAR_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_fast_cpu_reset_n <= 1'b1;
      end else begin
         o_fast_cpu_reset_n <= !(state == FGAR_WAIT && cnt == fgar_pkg::CNT_W'(DELAY_CYC - 1))
            && !(state == FGAR_PULSE && cnt != fgar_pkg::CNT_W'(PULSE_CYC - 1));
      end
   end

   // ----------------------------------------
   // Address mask and combined reset
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_fast_address_gate <= 1'b0;
         o_cpu_address_mask_n <= 1'b0;
         o_combined_cpu_reset <= 1'b0;
      end else begin
         o_fast_address_gate <= fast_gate;
         // Controller port bit is the software gate source
         o_cpu_address_mask_n <= i_kbc_gate_port_bit | fast_gate;
         // Fast reset only joins in while the port is enabled
         o_combined_cpu_reset <= i_reset_polarity ^
            (i_kbc_cpu_reset_n & (o_fast_cpu_reset_n | !port_en));
      end
   end

   // ----------------------------------------
   // Controller clock enable and reset stretch
   // ----------------------------------------
   // Fractional divider: one enable per reference edge scaled 12000/14318
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ref_d <= 1'b0;
         acc <= '0;
         o_kbc_clk_en <= 1'b0;
      end else begin
         ref_d <= i_ref_clk;
         o_kbc_clk_en <= 1'b0;
         if (i_ref_clk && !ref_d) begin
            if (acc + 16'(fgar_pkg::KBC_KHZ) >= 16'(fgar_pkg::REF_KHZ)) begin
               acc <= acc + 16'(fgar_pkg::KBC_KHZ) - 16'(fgar_pkg::REF_KHZ);
               o_kbc_clk_en <= 1'b1;
            end else begin
               acc <= acc + 16'(fgar_pkg::KBC_KHZ);
            end
         end
      end
   end

   // Reset to the controller stays low a minimum span after release
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         kbc_rst_cnt <= '0;
         o_kbc_reset_n <= 1'b0;
      end else if (kbc_rst_cnt != 6'(fgar_pkg::KBC_RST_CYC)) begin
         kbc_rst_cnt <= kbc_rst_cnt + 1'b1;
         o_kbc_reset_n <= 1'b0;
      end else begin
         o_kbc_reset_n <= 1'b1;
      end
   end

   // Port lines are low under reset and driven high afterwards; host status stays zero
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_kbd_clock_line <= 1'b0;
         o_kbd_data_line <= 1'b0;
         o_mouse_clock_line <= 1'b0;
         o_mouse_data_line <= 1'b0;
         o_host_status <= 8'h00;
      end else begin
         o_kbd_clock_line <= 1'b1;
         o_kbd_data_line <= 1'b1;
         o_mouse_clock_line <= 1'b1;
         o_mouse_data_line <= 1'b1;
         o_host_status <= 8'h00;
      end
   end

   // ----------------------------------------
   // Assertion helpers
   // ----------------------------------------
   // Run lengths of the wait and of the low pulse, so the delay and pulse-length checks
   // follow the parameters rather than a fixed repetition count
   logic [fgar_pkg::CNT_W-1:0] wait_run;
   logic [fgar_pkg::CNT_W-1:0] low_run;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         wait_run <= '0;
      end else if (state == FGAR_IDLE) begin
         wait_run <= '0;
      end else if (state == FGAR_WAIT) begin
         wait_run <= wait_run + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         low_run <= '0;
      end else if (!o_fast_cpu_reset_n) begin
         low_run <= low_run + 1'b1;
      end else begin
         low_run <= '0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_arm;
      state == FGAR_IDLE && fast_rst_bit;
   endsequence

   sequence s_pulse_start;
      $fell(o_fast_cpu_reset_n);
   endsequence

   sequence s_pulse_end;
      $rose(o_fast_cpu_reset_n);
   endsequence

   a_delay_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_pulse_start |-> wait_run >= fgar_pkg::CNT_W'(DELAY_CYC))
      else $error("fast reset delay shorter than set");

   a_pulse_delay: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_arm |=> o_fast_cpu_reset_n [*8])
      else $error("fast reset fired too early");

   a_pulse_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_pulse_end |-> low_run >= fgar_pkg::CNT_W'(PULSE_CYC))
      else $error("fast reset pulse too short");

   a_no_repeat: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state == FGAR_DONE && fast_rst_bit) |=> state == FGAR_DONE)
      else $error("second pulse without clearing bit 0");

   a_mask_or: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ##1 o_cpu_address_mask_n == ($past(i_kbc_gate_port_bit) | $past(fast_gate)))
      else $error("address mask not OR of gates");

   a_gate_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && port_hit) |=> ##1 o_fast_address_gate == $past(i_wdata[1], 2))
      else $error("address gate not following bit 1");

   a_port_blocked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && !port_en) |=> $stable(fast_gate) && $stable(fast_rst_bit))
      else $error("fast port written while disabled");

   a_read_fixed: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && port_hit) |=> (o_rdata & 8'hFC) == 8'h24)
      else $error("reserved bits read wrong");

   a_kbc_rst: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> !o_kbc_reset_n [*8])
      else $error("controller reset too short");

   a_comb_rst: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!i_kbc_cpu_reset_n && !i_reset_polarity) |=> !o_combined_cpu_reset)
      else $error("combined reset missed controller reset");

   a_reset_state: assert property (@(posedge i_mclk)
      !i_rst_n |=> o_fast_cpu_reset_n && !fast_rst_bit && !o_fast_address_gate)
      else $error("reset values wrong");

   a_read_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data outside read cycle");

   a_read_blocked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && !port_en && i_addr == fgar_pkg::ADDR_FAST_PORT) |=> o_rdata == 8'h00)
      else $error("disabled fast port answered a read");

   a_fast_joins: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (port_en && !o_fast_cpu_reset_n && !i_reset_polarity) |=> !o_combined_cpu_reset)
      else $error("combined reset missed fast reset");

   a_clk_en_single: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_kbc_clk_en |=> !o_kbc_clk_en)
      else $error("controller enable longer than one cycle");

   a_mask_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!i_kbc_gate_port_bit && !fast_gate) |=> !o_cpu_address_mask_n)
      else $error("address mask high with both gates low");

   a_gate_reset: assert property (@(posedge i_mclk)
      !i_rst_n |=> !fast_gate)
      else $error("address gate not low after reset");

   a_lines_reset: assert property (@(posedge i_mclk)
      !i_rst_n |=> !o_kbd_clock_line && !o_kbd_data_line && !o_mouse_clock_line
         && !o_mouse_data_line && o_host_status == 8'h00)
      else $error("port lines or status not cleared in reset");

endmodule : fgar_top

//--- tb/fgar_kbc_model.sv
// Partner model: keyboard-controller side signals and the 14.318 MHz reference.
// Assumes the bench sets the requests just after a rising edge of i_mclk.
`timescale 1ns/1ps
module fgar_kbc_model (
   input wire logic i_mclk,
   input wire logic i_gate,
   input wire logic i_rst_req,
   input wire logic i_pol,
   output logic o_ref_clk,
   output logic o_gate_port_bit,
   output logic o_cpu_reset_n,
   output logic o_reset_polarity
);
   // ----------------------------------------
   // Reference clock, free running
   // ----------------------------------------
   initial begin
      o_ref_clk = 1'b0;
      o_gate_port_bit = 1'b0;
      o_cpu_reset_n = 1'b1;
      o_reset_polarity = 1'b0;
      forever #34.921 o_ref_clk = ~o_ref_clk;
   end
   // ----------------------------------------
   // Controller port outputs, registered like the real core
   // ----------------------------------------
   always @(posedge i_mclk) begin
      o_gate_port_bit <= i_gate;
      o_cpu_reset_n <= !i_rst_req;
      o_reset_polarity <= i_pol;
   end
endmodule : fgar_kbc_model

//--- tb/fgar_top_tb.sv
// Self-checking bench for the fast gate and alternate reset block.
// Assumes the package, the design and the partner model are compiled first.
`timescale 1ns/1ps
module fgar_top_tb;
   localparam int DLY = 10;
   localparam int PLS = 5;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic gate = 1'b0;
   logic rst_req = 1'b0;
   logic pol = 1'b0;
   logic ref_clk, kbc_gate, kbc_rst_n, rst_pol, clk_en, kbc_out_n, fgate, frst_n, mask_n, comb;
   logic kbd_clock_line, kbd_data_line, mclk_l, mouse_data_line;
   logic [7:0] rdata, status, d;
   int fail_count = 0;
   int checks = 0;
   int n;
   int w;

   initial begin
      forever #12.5 i_mclk = ~i_mclk;
   end

   fgar_kbc_model kbc (.i_mclk(i_mclk), .i_gate(gate), .i_rst_req(rst_req), .i_pol(pol),
      .o_ref_clk(ref_clk), .o_gate_port_bit(kbc_gate), .o_cpu_reset_n(kbc_rst_n),
      .o_reset_polarity(rst_pol));

   fgar_top #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_ref_clk(ref_clk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(rdata), .i_kbc_gate_port_bit(kbc_gate), .i_kbc_cpu_reset_n(kbc_rst_n),
      .i_reset_polarity(rst_pol), .o_kbc_clk_en(clk_en), .o_kbc_reset_n(kbc_out_n),
      .o_fast_address_gate(fgate), .o_fast_cpu_reset_n(frst_n), .o_cpu_address_mask_n(mask_n),
      .o_combined_cpu_reset(comb), .o_kbd_clock_line(kbd_clock_line), .o_kbd_data_line(kbd_data_line),
      .o_mouse_clock_line(mclk_l), .o_mouse_data_line(mouse_data_line), .o_host_status(status));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task final_report();
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   task cyc(input int k);
      repeat (k) @(posedge i_mclk);
      #1;
   endtask : cyc

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 v = rdata;
   endtask : rd

   task do_reset();
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      cyc(10);
      check({2'b00, kbd_clock_line, kbd_data_line, mclk_l, mouse_data_line, frst_n, fgate}, 8'h02);
      check(status, 8'h00);
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      n = 0;
      cyc(1);
      while (kbc_out_n !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      check(8'(n >= fgar_pkg::KBC_RST_CYC - 2), 8'h01);
   endtask : do_reset

   // Bounded waits: a missing pulse shows as zero width
   task pulse(output int dly, output int wid);
      dly = 0;
      wid = 0;
      while (frst_n === 1'b1 && dly < 100) begin
         cyc(1);
         dly++;
      end
      while (frst_n === 1'b0 && wid < 100) begin
         if (wid == 2) check({7'h00, comb}, 8'h00);
         cyc(1);
         wid++;
      end
   endtask : pulse

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      do_reset();
      wr(8'h92, 8'h02);
      rd(8'h92, d);
      check(d, 8'h00);
      check({7'h00, fgate}, 8'h00);
      rd(8'h10, d);
      check(d, 8'h00);
      $display("Test access_disabled done");
      wr(8'hF0, 8'h04);
      for (int g = 0; g < 4; g++) begin
         gate <= g[1];
         wr(8'h92, {6'h00, g[0], 1'b0});
         cyc(3);
         check({6'h00, fgate, mask_n}, {6'h00, g[0], g != 0});
         rd(8'h92, d);
         check(d, {6'h09, g[0], 1'b0});
      end
      gate <= 1'b0;
      wr(8'h92, 8'h00);
      for (int p = 0; p < 4; p++) begin
         pol <= p[0];
         rst_req <= p[1];
         cyc(4);
         check({7'h00, comb}, {7'h00, p[0] ^ !p[1]});
      end
      pol <= 1'b0;
      rst_req <= 1'b0;
      $display("Test gate_and_polarity done");
      wr(8'h92, 8'h01);
      pulse(n, w);
      check(8'(n >= DLY && n <= DLY + 4), 8'h01);
      check(8'(w), 8'(PLS));
      wr(8'h92, 8'h01);
      pulse(n, w);
      check(8'(w), 8'h00);
      rd(8'h92, d);
      check(d, 8'h25);
      wr(8'h92, 8'h00);
      wr(8'h92, 8'h01);
      pulse(n, w);
      check(8'(w), 8'(PLS));
      $display("Test fast_reset done");
      wr(8'h92, 8'h00);
      wr(8'h92, 8'h01);
      cyc(3);
      do_reset();
      pulse(n, w);
      check(8'(w), 8'h00);
      wr(8'hF0, 8'h04);
      rd(8'h92, d);
      check(d, 8'h24);
      $display("Test reset_mid_wait done");
      n = 0;
      repeat (1000) begin
         cyc(1);
         if (clk_en === 1'b1) n++;
      end
      check(8'(n >= 290 && n <= 310), 8'h01);
      $display("Test controller_clock done");
      final_report();
   end

   initial begin
      #(25 * 10000);
      fail_count++;
      final_report();
   end
endmodule : fgar_top_tb
